/* File: common/xad_cfg.svh */
`ifndef XAD_CFG_SVH
`define XAD_CFG_SVH

// ****************************************
// Opcode groups (high nibble)
// ****************************************
`define XAD_HI_ADD      4'h2
`define XAD_HI_ADD_CARRY_OP     4'h3
`define XAD_HI_XOR      4'h6
`define XAD_HI_SUB_BORROW_OP     4'h9

// ****************************************
// Source field (low nibble)
// ****************************************
`define XAD_LO_DIR_ACC  4'h2
`define XAD_LO_DIR_IMM  4'h3
`define XAD_LO_IMM      4'h4
`define XAD_LO_DIR      4'h5
`define XAD_LO_IND      3'h3
`define XAD_LO_REG_BIT  3

// ****************************************
// Lengths and timing
// ****************************************
`define XAD_LEN_1       2'h1
`define XAD_LEN_2       2'h2
`define XAD_LEN_3       2'h3
`define XAD_CYC_1       2'h1
`define XAD_CYC_2       2'h2
`define XAD_PC_RST      16'h0000

`endif

/* File: common/xad_pkg.sv */
package xad_pkg;

    typedef enum logic [2:0] {
        xad_op_none = 3'h0,
        xad_op_xor  = 3'h1,
        xad_op_add  = 3'h2,
        xad_op_add_carry_op = 3'h3,
        xad_op_sub_borrow_op = 3'h4
    } xad_op_t;

    typedef enum logic [2:0] {
        xad_src_none = 3'h0,
        xad_src_reg  = 3'h1,
        xad_src_ind  = 3'h2,
        xad_src_dir  = 3'h3,
        xad_src_imm  = 3'h4,
        xad_src_acc  = 3'h5
    } xad_src_t;

    typedef enum logic {
        xad_dst_acc = 1'b0,
        xad_dst_dir = 1'b1
    } xad_dst_t;

    typedef enum logic [1:0] {
        xad_st_op   = 2'b00,
        xad_st_b1   = 2'b01,
        xad_st_b2   = 2'b11,
        xad_st_wait = 2'b10
    } xad_st_t;

    typedef struct packed {
        xad_op_t    op;
        xad_src_t   src;
        xad_dst_t   dst;
        logic [1:0] len;
        logic [1:0] cyc;
        logic [2:0] reg_idx;
    } xad_dec_t;

endpackage : xad_pkg

/* File: hw/xad_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
`include "xad_cfg.svh"

module xad_decoder
    import xad_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  code_byte,
    input  wire logic        code_valid,
    output logic             code_ready,
    output logic      [15:0] code_addr,
    output logic             dec_valid,
    output logic      [7:0]  dec_opcode,
    output xad_op_t          dec_op,
    output xad_src_t         dec_src,
    output xad_dst_t         dec_dst,
    output logic      [2:0]  dec_reg_idx,
    output logic      [7:0]  dec_byte1,
    output logic      [7:0]  dec_byte2,
    output logic      [1:0]  dec_len,
    output logic      [1:0]  dec_cycles,
    output logic             dec_flags_we,
    output logic             dec_from_latch
);

    // ****************************************
    // Opcode decode
    // ****************************************
    function automatic xad_dec_t dec_f(input logic [7:0] opc);
        xad_dec_t d;
        d = '{op: xad_op_none, src: xad_src_none, dst: xad_dst_acc,
              len: `XAD_LEN_1, cyc: `XAD_CYC_1, reg_idx: 3'h0};
        unique case (opc[7:4])
            `XAD_HI_ADD:  d.op = xad_op_add;
            `XAD_HI_ADD_CARRY_OP: d.op = xad_op_add_carry_op;
            `XAD_HI_SUB_BORROW_OP: d.op = xad_op_sub_borrow_op;
            `XAD_HI_XOR:  d.op = xad_op_xor;
            default:      d.op = xad_op_none;
        endcase
        if (opc[`XAD_LO_REG_BIT]) begin
            d.src     = xad_src_reg;
            d.reg_idx = opc[2:0];
        end else if (opc[3:1] == `XAD_LO_IND) begin
            d.src     = xad_src_ind;
            d.reg_idx = {2'h0, opc[0]};
        end else if (opc[3:0] == `XAD_LO_DIR) begin
            d.src = xad_src_dir;
            d.len = `XAD_LEN_2;
        end else if (opc[3:0] == `XAD_LO_IMM) begin
            d.src = xad_src_imm;
            d.len = `XAD_LEN_2;
        end else if (d.op == xad_op_xor && opc[3:0] == `XAD_LO_DIR_ACC) begin
            d.src = xad_src_acc;
            d.dst = xad_dst_dir;
            d.len = `XAD_LEN_2;
        end else if (d.op == xad_op_xor && opc[3:0] == `XAD_LO_DIR_IMM) begin
            d.src = xad_src_imm;
            d.dst = xad_dst_dir;
            d.len = `XAD_LEN_3;
            d.cyc = `XAD_CYC_2;
        end else begin
            d.op = xad_op_none;
        end
        // Unknown codes decode as one-byte no-ops so the fetch stream never stalls
        if (d.op == xad_op_none) begin
            d = '{op: xad_op_none, src: xad_src_none, dst: xad_dst_acc,
                  len: `XAD_LEN_1, cyc: `XAD_CYC_1, reg_idx: 3'h0};
        end
        return d;
    endfunction : dec_f

    // ****************************************
    // Fetch sequencer
    // ****************************************
    xad_st_t     st_ff,   nxt_st;
    logic [15:0] pc_ff,   nxt_pc;
    logic [7:0]  opc_ff,  nxt_opc;
    logic [7:0]  b1_ff,   nxt_b1;
    logic [7:0]  b2_ff,   nxt_b2;
    logic        vld_ff,  nxt_vld;
    xad_dec_t    dec_ff,  nxt_dec;
    logic [7:0]  oopc_ff, nxt_oopc;
    logic [7:0]  ob1_ff,  nxt_ob1;
    logic [7:0]  ob2_ff,  nxt_ob2;
    logic        take;
    logic        last;
    xad_dec_t    cur;

    assign code_ready = (st_ff != xad_st_wait);
    assign take       = code_valid && code_ready;

    always_comb begin
        nxt_st   = st_ff;
        nxt_pc   = pc_ff;
        nxt_opc  = opc_ff;
        nxt_b1   = b1_ff;
        nxt_b2   = b2_ff;
        nxt_vld  = 1'b0;
        nxt_dec  = dec_ff;
        nxt_oopc = oopc_ff;
        nxt_ob1  = ob1_ff;
        nxt_ob2  = ob2_ff;
        last     = 1'b0;
        if (take) begin
            nxt_pc = pc_ff + 16'h0001;
        end
        unique case (st_ff)
            xad_st_op: begin
                if (take) begin
                    nxt_opc = code_byte;
                    nxt_b1  = 8'h00;
                    nxt_b2  = 8'h00;
                end
            end
            xad_st_b1: begin
                if (take) begin
                    nxt_b1 = code_byte;
                end
            end
            xad_st_b2: begin
                if (take) begin
                    nxt_b2 = code_byte;
                end
            end
            xad_st_wait: begin
                nxt_st = xad_st_op;
            end
        endcase
        cur = dec_f(nxt_opc);
        if (take) begin
            unique case (st_ff)
                xad_st_op:   last = (cur.len == `XAD_LEN_1);
                xad_st_b1:   last = (cur.len == `XAD_LEN_2);
                xad_st_b2:   last = 1'b1;
                xad_st_wait: last = 1'b0;
            endcase
            if (!last) begin
                nxt_st = (st_ff == xad_st_op) ? xad_st_b1 : xad_st_b2;
            end else begin
                // Second machine cycle of a two-cycle form holds off the next fetch
                nxt_st   = (cur.cyc == `XAD_CYC_2) ? xad_st_wait : xad_st_op;
                nxt_vld  = 1'b1;
                nxt_dec  = cur;
                nxt_oopc = nxt_opc;
                nxt_ob1  = nxt_b1;
                nxt_ob2  = nxt_b2;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_ff   <= xad_st_op;
            pc_ff   <= `XAD_PC_RST;
            opc_ff  <= 8'h00;
            b1_ff   <= 8'h00;
            b2_ff   <= 8'h00;
            vld_ff  <= 1'b0;
            dec_ff  <= '{op: xad_op_none, src: xad_src_none, dst: xad_dst_acc,
                         len: `XAD_LEN_1, cyc: `XAD_CYC_1, reg_idx: 3'h0};
            oopc_ff <= 8'h00;
            ob1_ff  <= 8'h00;
            ob2_ff  <= 8'h00;
        end else begin
            st_ff   <= nxt_st;
            pc_ff   <= nxt_pc;
            opc_ff  <= nxt_opc;
            b1_ff   <= nxt_b1;
            b2_ff   <= nxt_b2;
            vld_ff  <= nxt_vld;
            dec_ff  <= nxt_dec;
            oopc_ff <= nxt_oopc;
            ob1_ff  <= nxt_ob1;
            ob2_ff  <= nxt_ob2;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign code_addr      = pc_ff;
    assign dec_valid      = vld_ff;
    assign dec_opcode     = oopc_ff;
    assign dec_op         = dec_ff.op;
    assign dec_src        = dec_ff.src;
    assign dec_dst        = dec_ff.dst;
    assign dec_reg_idx    = dec_ff.reg_idx;
    assign dec_byte1      = ob1_ff;
    assign dec_byte2      = ob2_ff;
    assign dec_len        = dec_ff.len;
    assign dec_cycles     = dec_ff.cyc;
    // Only arithmetic forms update flags
    assign dec_flags_we   = (dec_ff.op != xad_op_xor) && (dec_ff.op != xad_op_none);
    // Read-modify-write of a port must see the latch, or pins pulled low would corrupt it
    assign dec_from_latch = (dec_ff.dst == xad_dst_dir);

    // ****************************************
    // Checks
    // ****************************************
    logic [15:0] start_pc_ff, nxt_start_pc;

    always_comb begin
        nxt_start_pc = start_pc_ff;
        if (take && st_ff == xad_st_op) begin
            nxt_start_pc = pc_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            start_pc_ff <= `XAD_PC_RST;
        end else begin
            start_pc_ff <= nxt_start_pc;
        end
    end

    AST_XOR_DIR: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode == 8'h65 |-> dec_op == xad_op_xor && dec_src == xad_src_dir
            && dec_dst == xad_dst_acc && dec_len == 2'h2 && dec_cycles == 2'h1)
        else $error("direct xor decoded wrong");
    AST_XOR_IND: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode[7:1] == 7'h33 |-> dec_src == xad_src_ind && dec_len == 2'h1
            && dec_reg_idx == {2'h0, dec_opcode[0]} && dec_op == xad_op_xor)
        else $error("indirect xor decoded wrong");
    AST_XOR_IMM: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode == 8'h64 |-> dec_src == xad_src_imm && dec_dst == xad_dst_acc
            && dec_len == 2'h2 && dec_cycles == 2'h1)
        else $error("immediate xor decoded wrong");
    AST_XOR_TO_DIR: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode == 8'h62 |-> dec_dst == xad_dst_dir && dec_src == xad_src_acc)
        else $error("xor to direct byte decoded wrong");
    AST_XOR_DIR_IMM: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode == 8'h63 |-> dec_len == 2'h3 && dec_cycles == 2'h2
            && !code_ready ##1 code_ready)
        else $error("three-byte xor timing wrong");
    AST_ADD: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_op == xad_op_add |-> dec_cycles == 2'h1
            && dec_len == ((dec_src == xad_src_dir || dec_src == xad_src_imm) ? 2'h2 : 2'h1))
        else $error("add length or timing wrong");
    AST_ADD_CARRY_OP: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode[7:4] == 4'h3 && dec_opcode[3:2] != 2'h0 |-> dec_op == xad_op_add_carry_op
            && dec_flags_we && dec_cycles == 2'h1 && code_ready)
        else $error("add with carry decoded wrong");
    AST_SUB_BORROW_OP: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode[7:4] == 4'h9 && dec_opcode[3] |-> dec_op == xad_op_sub_borrow_op
            && dec_len == 2'h1 && dec_reg_idx == dec_opcode[2:0])
        else $error("subtract with borrow decoded wrong");
    AST_LATCH: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_op == xad_op_xor && dec_opcode[3:1] == 3'h1 |-> dec_from_latch)
        else $error("port xor not from latch");
    AST_NO_FLAGS: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode[7:4] == 4'h6 |-> !dec_flags_we)
        else $error("xor touches flags");
    AST_REG_IDX: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid && dec_opcode[3] && dec_op != xad_op_none |-> dec_reg_idx == dec_opcode[2:0])
        else $error("working register index wrong");
    AST_PC_LEN: assert property (@(posedge clk_sys) disable iff (!nrst)
        dec_valid |-> code_addr == start_pc_ff + {14'h0000, dec_len})
        else $error("counter not advanced by length");

endmodule : xad_decoder

`default_nettype wire

/* File: bench/xad_prog_mem.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Program memory model
// ****************************************
module xad_prog_mem (
    input  wire logic        clk_sys,
    input  wire logic [15:0] code_addr,
    input  wire logic        stall,
    output logic      [7:0]  code_byte,
    output logic             code_valid
);
    logic [7:0] mem_arr [0:1023];

    initial begin
        code_byte  = 8'h5a;
        code_valid = 1'b0;
    end

    // Driven off the falling edge so the decoder samples a settled byte
    always @(negedge clk_sys) begin
        code_valid <= ~stall;
        if (stall) begin
            code_byte <= ~code_byte; // Idle bus toggles so a stale byte never passes for data
        end else begin
            code_byte <= mem_arr[code_addr[9:0]];
        end
    end
endmodule : xad_prog_mem

`default_nettype wire

/* File: bench/tb_xor_and_arith_decode.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_xor_and_arith_decode
    import xad_pkg::*;
;
    logic        clk_sys;
    logic        nrst;
    logic        stall;
    logic [7:0]  code_byte;
    logic        code_valid;
    logic        code_ready;
    logic [15:0] code_addr;
    logic        dec_valid;
    logic [7:0]  dec_opcode;
    xad_op_t     dec_op;
    xad_src_t    dec_src;
    xad_dst_t    dec_dst;
    logic [2:0]  dec_reg_idx;
    logic [7:0]  dec_byte1;
    logic [7:0]  dec_byte2;
    logic [1:0]  dec_len;
    logic [1:0]  dec_cycles;
    logic        dec_flags_we;
    logic        dec_from_latch;
    logic [31:0] rng;
    int          n_mismatch;
    int          tests_run;
    logic [39:0] exp_q[$];
    logic [15:0] addr_q[$];

    xad_decoder uut (.clk_sys(clk_sys), .nrst(nrst), .code_byte(code_byte), .code_valid(code_valid),
        .code_ready(code_ready), .code_addr(code_addr), .dec_valid(dec_valid), .dec_opcode(dec_opcode),
        .dec_op(dec_op), .dec_src(dec_src), .dec_dst(dec_dst), .dec_reg_idx(dec_reg_idx),
        .dec_byte1(dec_byte1), .dec_byte2(dec_byte2), .dec_len(dec_len), .dec_cycles(dec_cycles),
        .dec_flags_we(dec_flags_we), .dec_from_latch(dec_from_latch));

    xad_prog_mem pmem (.clk_sys(clk_sys), .code_addr(code_addr), .stall(stall), .code_byte(code_byte),
        .code_valid(code_valid));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xorshift

    // Packs {opcode, op, src, dst, idx, byte1, byte2, len, cycles, flags_we, from_latch}
    function automatic logic [39:0] exp_dec(input logic [7:0] opc, input logic [7:0] b1, input logic [7:0] b2);
        xad_op_t    op;
        xad_src_t   src;
        xad_dst_t   dst;
        logic [2:0] idx;
        logic [1:0] len;
        logic [1:0] cyc;
        src = xad_src_none;
        dst = xad_dst_acc;
        idx = 3'h0;
        len = 2'h1;
        cyc = 2'h1;
        case (opc[7:4])
            4'h2: op = xad_op_add;
            4'h3: op = xad_op_add_carry_op;
            4'h6: op = xad_op_xor;
            4'h9: op = xad_op_sub_borrow_op;
            default: op = xad_op_none;
        endcase
        if (op == xad_op_none) begin
            src = xad_src_none;
        end else if (opc[3]) begin
            src = xad_src_reg;
            idx = opc[2:0];
        end else if (opc[3:1] == 3'h3) begin
            src = xad_src_ind;
            idx = {2'h0, opc[0]};
        end else if (opc[3:1] == 3'h2) begin
            src = opc[0] ? xad_src_dir : xad_src_imm;
            len = 2'h2;
        end else if (op == xad_op_xor && opc[3:1] == 3'h1) begin
            src = opc[0] ? xad_src_imm : xad_src_acc;
            dst = xad_dst_dir;
            len = opc[0] ? 2'h3 : 2'h2;
            cyc = opc[0] ? 2'h2 : 2'h1;
        end else begin
            op = xad_op_none;
        end
        return {opc, op, src, dst, idx, (len > 2'h1) ? b1 : 8'h00, (len == 2'h3) ? b2 : 8'h00, len, cyc,
                (op != xad_op_none && op != xad_op_xor), dst == xad_dst_dir};
    endfunction : exp_dec

    task automatic check(input logic [39:0] seen, input logic [39:0] expd);
        tests_run++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, expd);
        end
    endtask : check

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // Clock and stalls
    // ****************************************
    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    // Random stalls exercise the sequencer waiting between operand bytes
    always @(negedge clk_sys) begin
        if (!nrst) begin
            rng <= 32'hb61deca8;
        end else begin
            rng <= xorshift(rng);
        end
        stall <= ~nrst | (rng[1:0] == 2'h0);
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin : main_seq
        int          pc;
        int          w;
        logic [39:0] e;
        logic [31:0] r;
        nrst = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        r = 32'hb61deca8;
        pc = 0;
        // First 256 instructions walk every opcode; random ones follow
        for (int k = 0; pc < 1000; k++) begin
            r = xorshift(r);
            pmem.mem_arr[pc] = (k < 256) ? k[7:0] : r[7:0];
            pmem.mem_arr[pc + 1] = r[15:8];
            pmem.mem_arr[pc + 2] = r[23:16];
            e = exp_dec(pmem.mem_arr[pc], r[15:8], r[23:16]);
            exp_q.push_back(e);
            pc = pc + int'(e[5:4]);
            addr_q.push_back(pc[15:0]);
        end
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        check({22'h0, code_addr, dec_valid, code_ready}, {22'h0, 16'h0000, 1'b0, 1'b1});
        nrst <= 1'b1;
        for (int k = 0; k < exp_q.size(); k++) begin
            w = 0;
            do begin
                @(negedge clk_sys);
                w++;
            end while (dec_valid !== 1'b1 && w < 40);
            if (dec_valid !== 1'b1) begin
                check({39'h0, dec_valid}, {39'h0, 1'b1});
                break;
            end
            check({dec_opcode, dec_op, dec_src, dec_dst, dec_reg_idx, dec_byte1, dec_byte2, dec_len, dec_cycles,
                   dec_flags_we, dec_from_latch}, exp_q[k]);
            check({24'h0, code_addr}, {24'h0, addr_q[k]});
            check({39'h0, code_ready}, {39'h0, exp_q[k][3:2] == 2'h1});
        end
        test_done();
    end
endmodule : tb_xor_and_arith_decode

`default_nettype wire
